// File: usi_defines.vh
// register map, field layout and reset values of the special/status irq block
`ifndef USI_DEFINES_VH
`define USI_DEFINES_VH

// register indexes; byte address is four times the index
`define USI_IDX_IRQ_MASK      6'h01
`define USI_IDX_TOP_IRQ       6'h02
`define USI_IDX_SPC_EN        6'h05
`define USI_IDX_SPC_FLAGS     6'h06
`define USI_IDX_STS_EN        6'h07
`define USI_IDX_STS_FLAGS     6'h08
`define USI_IDX_SECOND_MODE_REGISTER         6'h0A
`define USI_IDX_CLK_CFG       6'h0B

// implemented bits per register
`define USI_SPC_MASK          8'h3F
`define USI_STS_MASK          8'h2F
`define USI_TOP_MASK          8'h06
`define USI_SECOND_MODE_REGISTER_MASK        8'h50
`define USI_CLK_CFG_MASK      8'h03

// reset values
`define USI_SPC_EN_RST        8'h00
`define USI_STS_EN_RST        8'h00
`define USI_IRQ_MASK_RST      8'h00
`define USI_SECOND_MODE_REGISTER_RST         8'h00
`define USI_CLK_CFG_RST       8'h00

// field positions
`define USI_TOP_SPECIAL_BIT   1
`define USI_TOP_STATUS_BIT    2
`define USI_SECOND_MODE_REGISTER_SPCHR_BIT   4
`define USI_SECOND_MODE_REGISTER_MDROP_BIT   6
`define USI_STS_CLKRDY_BIT    5
`define USI_CLK_XTAL_BIT      0
`define USI_CLK_ENABLE_BIT    1

// gpio lines owned by each uart instance
`define USI_GPIO_PER_UART     4

`endif

// File: usi_flag_bank.v
// bank of sticky event flags, set wins over clear
`timescale 1ns/100ps

module usi_flag_bank #(
    parameter W = 6
) (
    input  wire         i_mclk,
    input  wire         i_reset_n,
    input  wire [W-1:0] i_set,
    input  wire         i_clr,
    output wire [W-1:0] o_flags
);

    reg [W-1:0] flags_q;

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_flag
            always @(posedge i_mclk) begin
                if (!i_reset_n) begin
                    flags_q[g] <= 1'b0;
                end else if (i_set[g]) begin
                    flags_q[g] <= 1'b1;
                end else if (i_clr) begin
                    flags_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign o_flags = flags_q;

endmodule

// File: usi_irq.v
// special-character and status interrupt sources of one uart, apb slave
// Functional notes
// - six special flags gated by own enables
// - special enables reset zero, low masks
// - address flag set in multidrop mode
// - break flag set on long low line
// - flow char flags need special detect
// - special flag read returns, then clears
// - clock-ready routed only when enabled
// - gpio change enables route flags to summary
// - instance n owns gpio 4n to 4n+3
// - clock-ready set when clocking settled
// - clock-ready only with crystal source
// - clock-ready cleared only by clock disable
// - gpio change sets flag, read clears
// - status summary from enabled status flags
// - special summary cleared by top read
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`include "usi_defines.vh"

module usi_irq #(
    parameter UART_INDEX = 0,
    parameter ADDR_W     = 8
) (
    input  wire              i_mclk,
    input  wire              i_reset_n,
    input  wire [ADDR_W-1:0] i_paddr,
    input  wire              i_psel,
    input  wire              i_penable,
    input  wire              i_pwrite,
    input  wire [31:0]       i_pwdata,
    output wire [31:0]       o_prdata,
    output wire              o_pready,
    output wire              o_pslverr,
    input  wire              i_addr_char,
    input  wire              i_line_break,
    input  wire              i_stop_char1,
    input  wire              i_stop_char2,
    input  wire              i_resume_char1,
    input  wire              i_resume_char2,
    input  wire              i_clk_settled,
    input  wire [15:0]       i_gpio,
    output wire              o_irq,
    output wire              o_multidrop_en,
    output wire              o_special_chr_en,
    output wire              o_clock_enable,
    output wire              o_xtal_select
);

    localparam GPIO_LO = UART_INDEX * `USI_GPIO_PER_UART;

    // decode of an aligned register index
    function hit;
        input [ADDR_W-1:0] addr;
        input [5:0]        idx;
        reg   [ADDR_W+5:0] addr_x;
        reg   [ADDR_W+5:0] want_x;
        begin
            addr_x = {6'b000000, addr};
            want_x = {{ADDR_W{1'b0}}, idx};
            hit    = (addr_x == {want_x[ADDR_W+3:0], 2'b00});
        end
    endfunction

    // bus state
    reg  [31:0] prdata_q;
    reg  [31:0] prdata_d;
    reg         pready_q;
    reg         pslverr_q;
    reg         pslverr_d;

    // software registers
    reg  [7:0]  spc_en_q;
    reg  [7:0]  sts_en_q;
    reg  [7:0]  irq_mask_q;
    reg  [7:0]  second_mode_register_q;
    reg  [7:0]  clk_cfg_q;

    // clock-ready and gpio tracking
    reg         clk_rdy_q;
    reg  [3:0]  gpio_prev_q;
    reg         gpio_valid_q;
    reg         irq_q;

    wire        setup;
    wire        access;
    wire        rd_setup;
    wire        wr_access;
    wire        mapped;
    wire [3:0]  gpio_own;
    wire [3:0]  gpio_change;
    wire [5:0]  spc_set;
    wire [5:0]  spc_flags;
    wire [3:0]  gpi_flags;
    wire [1:0]  top_set;
    wire [1:0]  top_flags;
    wire [7:0]  spc_flags_r;
    wire [7:0]  sts_flags_r;
    wire [7:0]  top_r;
    wire        spc_any;
    wire        sts_any;
    wire        clr_spc;
    wire        clr_sts;
    wire        clr_top;
    wire        sel_irq_mask;
    wire        sel_top;
    wire        sel_spc_en;
    wire        sel_spc_flags;
    wire        sel_sts_en;
    wire        sel_sts_flags;
    wire        sel_second_mode_register;
    wire        sel_clk_cfg;
    wire [5:0]  spc_event;
    wire [5:0]  spc_qual;
    wire [7:0]  spc_masked;
    wire [7:0]  sts_masked;
    wire        irq_d;

    // apb phases; read side effects at the setup edge, writes at access
    assign setup     = i_psel && !i_penable;
    assign access    = i_psel && i_penable && pready_q;
    assign rd_setup  = setup && !i_pwrite;
    assign wr_access = access && i_pwrite;

    // register selects
    assign sel_irq_mask  = hit(i_paddr, `USI_IDX_IRQ_MASK);
    assign sel_top       = hit(i_paddr, `USI_IDX_TOP_IRQ);
    assign sel_spc_en    = hit(i_paddr, `USI_IDX_SPC_EN);
    assign sel_spc_flags = hit(i_paddr, `USI_IDX_SPC_FLAGS);
    assign sel_sts_en    = hit(i_paddr, `USI_IDX_STS_EN);
    assign sel_sts_flags = hit(i_paddr, `USI_IDX_STS_FLAGS);
    assign sel_second_mode_register     = hit(i_paddr, `USI_IDX_SECOND_MODE_REGISTER);
    assign sel_clk_cfg   = hit(i_paddr, `USI_IDX_CLK_CFG);

    assign mapped = sel_irq_mask  || sel_top    || sel_spc_en    ||
                    sel_spc_flags || sel_sts_en || sel_sts_flags ||
                    sel_second_mode_register     || sel_clk_cfg;

    // special events and their mode qualifiers
    assign spc_event = {
        i_addr_char,
        i_line_break,
        i_stop_char2,
        i_stop_char1,
        i_resume_char2,
        i_resume_char1
    };
    assign spc_qual = {
        second_mode_register_q[`USI_SECOND_MODE_REGISTER_MDROP_BIT],
        1'b1,
        {4{second_mode_register_q[`USI_SECOND_MODE_REGISTER_SPCHR_BIT]}}
    };
    assign spc_set = spc_event & spc_qual;

    assign clr_spc = rd_setup && sel_spc_flags;
    assign clr_sts = rd_setup && sel_sts_flags;
    assign clr_top = rd_setup && sel_top;

    usi_flag_bank #(
        .W (6)
    ) u_spc_flags (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_set     (spc_set),
        .i_clr     (clr_spc),
        .o_flags   (spc_flags)
    );

    // gpio change detection on the four owned lines
    assign gpio_own    = i_gpio[GPIO_LO +: 4];
    assign gpio_change = gpio_valid_q ? (gpio_own ^ gpio_prev_q) : 4'h0;

    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            gpio_prev_q  <= 4'h0;
            gpio_valid_q <= 1'b0;
        end else begin
            gpio_prev_q  <= gpio_own;
            gpio_valid_q <= 1'b1;
        end
    end

    usi_flag_bank #(
        .W (4)
    ) u_gpi_flags (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_set     (gpio_change),
        .i_clr     (clr_sts),
        .o_flags   (gpi_flags)
    );

    // clock-ready status, not touched by reads
    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            clk_rdy_q <= 1'b0;
        end else if (!clk_cfg_q[`USI_CLK_ENABLE_BIT]) begin
            clk_rdy_q <= 1'b0;
        end else if (clk_cfg_q[`USI_CLK_XTAL_BIT] && i_clk_settled) begin
            clk_rdy_q <= 1'b1;
        end
    end

    // summary bits
    assign spc_flags_r = {2'b00, spc_flags};
    assign sts_flags_r = {2'b00, clk_rdy_q, 1'b0, gpi_flags};

    assign spc_masked = spc_flags_r & spc_en_q;
    assign sts_masked = sts_flags_r & sts_en_q;
    assign spc_any    = |spc_masked;
    assign sts_any    = |sts_masked;

    assign top_set = {sts_any, spc_any};

    usi_flag_bank #(
        .W (2)
    ) u_top_flags (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_set     (top_set),
        .i_clr     (clr_top),
        .o_flags   (top_flags)
    );

    assign top_r = {5'b00000, top_flags, 1'b0};

    // software-written registers
    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            spc_en_q <= `USI_SPC_EN_RST;
        end else if (wr_access && sel_spc_en) begin
            spc_en_q <= i_pwdata[7:0] & `USI_SPC_MASK;
        end
    end

    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            sts_en_q <= `USI_STS_EN_RST;
        end else if (wr_access && sel_sts_en) begin
            sts_en_q <= i_pwdata[7:0] & `USI_STS_MASK;
        end
    end

    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            irq_mask_q <= `USI_IRQ_MASK_RST;
        end else if (wr_access && sel_irq_mask) begin
            irq_mask_q <= i_pwdata[7:0] & `USI_TOP_MASK;
        end
    end

    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            second_mode_register_q <= `USI_SECOND_MODE_REGISTER_RST;
        end else if (wr_access && sel_second_mode_register) begin
            second_mode_register_q <= i_pwdata[7:0] & `USI_SECOND_MODE_REGISTER_MASK;
        end
    end

    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            clk_cfg_q <= `USI_CLK_CFG_RST;
        end else if (wr_access && sel_clk_cfg) begin
            clk_cfg_q <= i_pwdata[7:0] & `USI_CLK_CFG_MASK;
        end
    end

    // read mux
    always @* begin
        prdata_d = 32'h0000_0000;
        if (sel_irq_mask) begin
            prdata_d[7:0] = irq_mask_q;
        end else if (sel_top) begin
            prdata_d[7:0] = top_r;
        end else if (sel_spc_en) begin
            prdata_d[7:0] = spc_en_q;
        end else if (sel_spc_flags) begin
            prdata_d[7:0] = spc_flags_r;
        end else if (sel_sts_en) begin
            prdata_d[7:0] = sts_en_q;
        end else if (sel_sts_flags) begin
            prdata_d[7:0] = sts_flags_r;
        end else if (sel_second_mode_register) begin
            prdata_d[7:0] = second_mode_register_q;
        end else if (sel_clk_cfg) begin
            prdata_d[7:0] = clk_cfg_q;
        end
    end

    always @* begin
        pslverr_d = !mapped;
    end

    // zero-wait apb answer: ready in the first access cycle
    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= setup;
        end
    end

    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !i_pwrite) begin
            prdata_q <= prdata_d;
        end else begin
            prdata_q <= 32'h0000_0000;
        end
    end

    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pslverr_q <= pslverr_d;
        end else begin
            pslverr_q <= 1'b0;
        end
    end

    // interrupt output
    assign irq_d = |(top_r & irq_mask_q);

    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign o_prdata         = prdata_q;
    assign o_pready         = pready_q;
    assign o_pslverr        = pslverr_q;
    assign o_irq            = irq_q;
    assign o_multidrop_en   = second_mode_register_q[`USI_SECOND_MODE_REGISTER_MDROP_BIT];
    assign o_special_chr_en = second_mode_register_q[`USI_SECOND_MODE_REGISTER_SPCHR_BIT];
    assign o_clock_enable   = clk_cfg_q[`USI_CLK_ENABLE_BIT];
    assign o_xtal_select    = clk_cfg_q[`USI_CLK_XTAL_BIT];

endmodule

// File: usi_irq_monitor.sv
// port checker of the special/status irq block
`timescale 1ns/100ps

module usi_irq_monitor #(
    parameter ADDR_W = 8
) (
    input wire              i_mclk,
    input wire              i_reset_n,
    input wire [ADDR_W-1:0] i_paddr,
    input wire              i_psel,
    input wire              i_penable,
    input wire              i_pwrite,
    input wire [31:0]       o_prdata,
    input wire              o_pready,
    input wire              o_pslverr,
    input wire              o_irq,
    input wire              o_clock_enable
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    wire rd_sts = o_pready && !i_pwrite && i_paddr == 8'h20;
    wire rd_top = o_pready && !i_pwrite && i_paddr == 8'h08;

    a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (o_pready |=> !o_pready)
        else $error("ready held too long");
    a_data_idle_zero: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside access");
    a_upper_bits_zero: assert property (o_prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_err_with_ready: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    a_reset_quiet: assert property (disable iff (1'b0)
        !i_reset_n |=> !o_irq && !o_clock_enable)
        else $error("outputs active after reset");
    a_clkrdy_needs_en: assert property (rd_sts &&
        !$past(o_clock_enable) && !$past(o_clock_enable, 2) |-> !o_prdata[5])
        else $error("clock ready with clock off");
    a_top_bits_only: assert property (rd_top |->
        (o_prdata[7:0] & 8'hF9) == 8'h00)
        else $error("unused top bit set");

    c_clk_ready: cover property (rd_sts && o_prdata[5]);
    c_slv_err: cover property (o_pslverr);
    c_irq_rise: cover property ($rose(o_irq));
endmodule

bind usi_irq usi_irq_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_paddr(i_paddr),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_irq(o_irq), .o_clock_enable(o_clock_enable));

// File: usi_irq_tb.sv
// self-checking bench of the special/status irq block
`timescale 1ns/100ps
`include "usi_defines.vh"

module usi_irq_tb;
    logic        i_mclk, i_reset_n, i_psel, i_penable, i_pwrite;
    logic [7:0]  i_paddr;
    logic [31:0] i_pwdata, rdat;
    logic [5:0]  ev;
    logic        i_clk_settled, rerr;
    logic [15:0] i_gpio;
    wire  [31:0] o_prdata;
    wire         o_pready, o_pslverr, o_irq;
    wire         o_multidrop_en, o_special_chr_en;
    wire         o_clock_enable, o_xtal_select;
    int          bad_count = 0;
    int          tests_run = 0;
    // index, readback after writing all ones, error flag
    logic [14:0] rows [9] = '{
        {`USI_IDX_SPC_EN, `USI_SPC_MASK, 1'b0},
        {`USI_IDX_STS_EN, `USI_STS_MASK, 1'b0},
        {`USI_IDX_IRQ_MASK, `USI_TOP_MASK, 1'b0},
        {`USI_IDX_SECOND_MODE_REGISTER, `USI_SECOND_MODE_REGISTER_MASK, 1'b0},
        {`USI_IDX_CLK_CFG, `USI_CLK_CFG_MASK, 1'b0},
        {`USI_IDX_SPC_FLAGS, 8'h00, 1'b0},
        {`USI_IDX_STS_FLAGS, 8'h00, 1'b0},
        {`USI_IDX_TOP_IRQ, 8'h00, 1'b0},
        {6'h03, 8'h00, 1'b1}};

    usi_irq #(.UART_INDEX(2)) dut_u (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_paddr(i_paddr),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_addr_char(ev[5]),
        .i_line_break(ev[4]), .i_stop_char2(ev[3]),
        .i_stop_char1(ev[2]), .i_resume_char2(ev[1]),
        .i_resume_char1(ev[0]), .i_clk_settled(i_clk_settled),
        .i_gpio(i_gpio), .o_irq(o_irq), .o_multidrop_en(o_multidrop_en),
        .o_special_chr_en(o_special_chr_en),
        .o_clock_enable(o_clock_enable), .o_xtal_select(o_xtal_select));

    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic [5:0] idx, input logic wr,
                       input logic [7:0] wd, input logic brk);
        @(posedge i_mclk);
        i_paddr <= {idx, 2'b00};
        i_pwrite <= wr;
        i_pwdata <= {24'h0, wd};
        i_psel <= 1'b1;
        ev[4] <= brk;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        ev[4] <= 1'b0;
        do begin
            @(posedge i_mclk);
        end while (o_pready !== 1'b1);
        rdat = o_prdata;
        rerr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] idx, input logic [7:0] exp,
                      input logic brk);
        apb(idx, 1'b0, 8'h00, brk);
        chk(rdat, {24'h0, exp});
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        apb(idx, 1'b1, d, 1'b0);
        repeat (3) @(posedge i_mclk);
    endtask

    task automatic pulse(input logic [5:0] v);
        @(posedge i_mclk);
        ev <= v;
        @(posedge i_mclk);
        ev <= 6'h00;
        repeat (3) @(posedge i_mclk);
    endtask

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge i_mclk);
        bad_count++;
        end_of_test;
    end

    initial begin
        {i_reset_n, i_psel, i_penable, i_pwrite, i_clk_settled} = 5'h00;
        {i_paddr, i_pwdata, ev, i_gpio} = 62'h0;
        repeat (4) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        foreach (rows[k]) begin
            wr(rows[k][14:9], 8'hFF);
            rd(rows[k][14:9], rows[k][8:1], 1'b0);
            chk(rerr, rows[k][0]);
        end
        i_reset_n <= 1'b0;
        repeat (4) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        chk({o_multidrop_en, o_special_chr_en, o_clock_enable,
             o_xtal_select, o_irq}, 32'h0);
        foreach (rows[k]) rd(rows[k][14:9], 8'h00, 1'b0);
        pulse(6'h3F);
        rd(6'h06, 8'h10, 1'b0);
        wr(6'h0A, 8'h50);
        chk({o_multidrop_en, o_special_chr_en}, 32'h3);
        pulse(6'h3F);
        rd(6'h02, 8'h00, 1'b0);
        wr(6'h05, 8'h20);
        wr(6'h01, 8'h06);
        chk(o_irq, 1'b1);
        rd(6'h06, 8'h3F, 1'b0);
        rd(6'h06, 8'h00, 1'b0);
        rd(6'h02, 8'h02, 1'b0);
        rd(6'h02, 8'h00, 1'b0);
        chk(o_irq, 1'b0);
        pulse(6'h1E);
        rd(6'h02, 8'h00, 1'b0);
        rd(6'h06, 8'h1E, 1'b0);
        rd(6'h06, 8'h00, 1'b1);
        rd(6'h06, 8'h10, 1'b0);
        i_gpio <= 16'hF0FF;
        wr(6'h02, 8'h00);
        rd(6'h08, 8'h00, 1'b0);
        i_gpio <= 16'hF2FF;
        wr(6'h02, 8'h00);
        rd(6'h02, 8'h00, 1'b0);
        wr(6'h07, 8'h02);
        rd(6'h02, 8'h04, 1'b0);
        chk(o_irq, 1'b1);
        rd(6'h08, 8'h02, 1'b0);
        rd(6'h08, 8'h00, 1'b0);
        i_clk_settled <= 1'b1;
        wr(6'h0B, 8'h02);
        rd(6'h08, 8'h00, 1'b0);
        wr(6'h0B, 8'h03);
        chk({o_clock_enable, o_xtal_select}, 32'h3);
        apb(6'h02, 1'b0, 8'h00, 1'b0);
        rd(6'h08, 8'h20, 1'b0);
        rd(6'h02, 8'h00, 1'b0);
        wr(6'h07, 8'h20);
        rd(6'h02, 8'h04, 1'b0);
        rd(6'h08, 8'h20, 1'b0);
        wr(6'h0B, 8'h01);
        chk({o_clock_enable, o_xtal_select}, 32'h1);
        rd(6'h08, 8'h00, 1'b0);
        end_of_test;
    end
endmodule
